// ### rtl/maap_pkg.sv
package maap_pkg;

  // ****************************************
  // region attributes
  // ****************************************
  typedef enum logic [1:0] {
    MAAP_NORMAL = 2'b00,
    MAAP_DEVICE = 2'b01,
    MAAP_STRONG = 2'b10,
    MAAP_RSVD   = 2'b11
  } maap_type_t;

  typedef enum logic [1:0] {
    MAAP_NC   = 2'b00,
    MAAP_WT   = 2'b01,
    MAAP_WBWA = 2'b10,
    MAAP_WBNA = 2'b11
  } maap_cache_t;

  typedef enum logic [2:0] {
    MAAP_OK     = 3'h0,
    MAAP_BADTYP = 3'h1,
    MAAP_SPEC   = 3'h2,
    MAAP_ALIGN  = 3'h3,
    MAAP_RDONLY = 3'h4
  } maap_deny_t;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] MAAP_REG_CTRL = 8'h00;
  localparam logic [7:0] MAAP_REG_ISSUED = 8'h04;
  localparam logic [7:0] MAAP_REG_DENIED = 8'h08;
  localparam logic [7:0] MAAP_REG_STATUS = 8'h0c;
  localparam int MAAP_CTRL_W = 4;
  localparam logic [3:0] MAAP_CTRL_RESET = 4'h7;
  localparam int MAAP_CB_SHCACHE = 0;
  localparam int MAAP_CB_PREFETCH = 1;
  localparam int MAAP_CB_MERGE = 2;
  localparam int MAAP_CB_ALIGN = 3;
  localparam int MAAP_CNT_W = 16;

  // ****************************************
  // byte lanes
  // ****************************************
  localparam logic [1:0] MAAP_SZ_BYTE = 2'h0;
  localparam logic [1:0] MAAP_SZ_HALF = 2'h1;
  localparam logic [1:0] MAAP_SZ_WORD = 2'h2;
  localparam logic [3:0] MAAP_LANE_B = 4'h1;
  localparam logic [3:0] MAAP_LANE_H = 4'h3;
  localparam logic [3:0] MAAP_LANE_W = 4'hf;

endpackage

// ### rtl/maap_pol_if.sv
`timescale 1ns/10ps
interface maap_pol_if;
  import maap_pkg::*;
  // access and attributes
  maap_type_t  mem_type;
  maap_cache_t cache;
  logic        shareable;
  logic        read_only;
  logic        write;
  logic        spec;
  logic [1:0]  size;
  logic [1:0]  addr_lo;
  logic [3:0]  ctrl;
  // decisions
  logic        is_normal;
  logic        is_device;
  logic        share_eff;
  logic        cacheable;
  logic        allocate;
  logic        excl_global;
  logic        may_prefetch;
  logic        may_repeat;
  logic        may_merge;
  logic        unaligned;
  logic        deny;
  maap_deny_t  deny_code;

  modport cls (input mem_type, cache, shareable, read_only, write, spec, size, addr_lo, ctrl,
               output is_normal, is_device, share_eff, cacheable, allocate, excl_global,
               may_prefetch, may_repeat, may_merge, unaligned, deny, deny_code);
  modport user (output mem_type, cache, shareable, read_only, write, spec, size, addr_lo, ctrl,
                input is_normal, is_device, share_eff, cacheable, allocate, excl_global,
                may_prefetch, may_repeat, may_merge, unaligned, deny, deny_code);
endinterface

// ### rtl/maap_classify.sv
`timescale 1ns/10ps
module maap_classify (
  // policy lookup
  maap_pol_if.cls pol
);
  import maap_pkg::*;

  // ****************************************
  // type and cacheability decode
  // ****************************************
  // strongly-ordered rides the device path and is always shared
  always_comb begin
    pol.is_normal = (pol.mem_type == MAAP_NORMAL);                           // [RL1]
    pol.is_device = (pol.mem_type == MAAP_DEVICE) || (pol.mem_type == MAAP_STRONG);
    pol.share_eff = pol.shareable || (pol.mem_type == MAAP_STRONG);           // [RL23]
    // shared regions stay uncached unless coherency is enabled
    pol.cacheable = pol.is_normal && (pol.cache != MAAP_NC) &&
                    (!pol.shareable || pol.ctrl[MAAP_CB_SHCACHE]);            // [RL9] [RL11] [RL12]
    pol.allocate = pol.cacheable && (!pol.write || pol.cache == MAAP_WBWA);    // [RL11] [RL16]
    pol.excl_global = pol.share_eff;                                          // [RL8] [RL10]
    pol.may_prefetch = pol.is_normal && !pol.write && pol.ctrl[MAAP_CB_PREFETCH]; // [RL2]
    pol.may_repeat = pol.is_normal;                                           // [RL2] [RL3] [RL14]
    pol.may_merge = pol.is_normal && pol.write && pol.ctrl[MAAP_CB_MERGE];      // [RL5] [RL17]
  end

  // ****************************************
  // alignment and refusal
  // ****************************************
  // normal accesses may be unaligned; device ones fault when checking is on
  always_comb begin
    pol.unaligned = ((pol.size == MAAP_SZ_HALF) && pol.addr_lo[0]) ||
                    ((pol.size == MAAP_SZ_WORD) && (pol.addr_lo != 2'h0));    // [RL4]
    pol.deny_code = MAAP_OK;
    if (pol.mem_type == MAAP_RSVD) begin
      pol.deny_code = MAAP_BADTYP;                                            // [RL1]
    end else if (pol.is_device && pol.spec) begin
      pol.deny_code = MAAP_SPEC;                                              // [RL15]
    end else if (pol.is_device && pol.unaligned && pol.ctrl[MAAP_CB_ALIGN]) begin
      pol.deny_code = MAAP_ALIGN;                                             // [RL21]
    end else if (pol.is_normal && pol.read_only && pol.write) begin
      pol.deny_code = MAAP_RDONLY;                                            // [RL6]
    end
    pol.deny = (pol.deny_code != MAAP_OK);
  end

endmodule

// ### rtl/maap_policy.sv
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// RL1: every region has one of three memory types; reserved code is refused.
// RL2: normal reads may be repeated and prefetched.
// RL3: normal writes may repeat only while the location is unchanged.
// RL4: normal accesses may be unaligned.
// RL5: normal writes may be merged before reaching memory.
// RL6: normal regions track read-only and shareable; read-only writes fault.
// RL7: normal ordering is weak; barriers drain merged writes first.
// RL8: non-shareable normal exclusives need only local monitoring.
// RL9: shareable normal caching must be transparent, else kept uncached.
// RL10: shareable normal exclusives are monitored for all observers.
// RL11: normal regions carry one of four cacheability classes.
// RL12: cacheability is decided independently of shareability; here a shareable normal region is cacheable only with MAAP_CB_SHCACHE set.
// RL13: device accesses go out at program size and program count.
// RL14: device accesses are never repeated by this logic.
// RL15: speculative device accesses are refused.
// RL16: device accesses are never cached nor allocated.
// RL17: device writes may be buffered but never merged here.
// RL18: device accesses are never coalesced.
// RL19: a restarted multi-access instruction may repeat accesses; flagged through.
// RL20: software avoids multi-access device writes that could restart.
// RL21: unaligned device access is undefined unless alignment checking faults it.
// RL22: software places a barrier after device side effects on normal memory.
// RL23: device regions are shareable or local; local ones route privately.
// RL24: policy decisions use type, shareability and cache class inputs.
module maap_policy #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [31:0]          reg_rdata,
  // pipeline request
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [ADDR_W-1:0]    req_addr,
  input  wire logic                 req_write,
  input  wire logic [1:0]           req_size,
  input  wire logic [31:0]          req_wdata,
  input  wire logic                 req_spec,
  input  wire logic                 req_excl,
  input  wire logic                 req_restart,
  input  wire logic                 req_barrier,
  // region attributes
  input  wire maap_pkg::maap_type_t  attr_type,
  input  wire maap_pkg::maap_cache_t attr_cache,
  input  wire logic                 attr_shareable,
  input  wire logic                 attr_read_only,
  // pipeline answer and hints
  output logic                      resp_fault,
  output maap_pkg::maap_deny_t      resp_code,
  output logic                      hint_prefetch,
  output logic                      hint_repeat,
  // memory side
  output logic                      mem_valid,
  input  wire logic                 mem_ready,
  output logic      [ADDR_W-1:0]    mem_addr,
  output logic                      mem_write,
  output logic      [1:0]           mem_size,
  output logic      [31:0]          mem_wdata,
  output logic      [3:0]           mem_strb,
  output logic                      mem_cacheable,
  output logic                      mem_allocate,
  output logic                      mem_shareable,
  output logic                      mem_excl,
  output logic                      mem_excl_global,
  output logic                      mem_device,
  output logic                      mem_local,
  output logic                      mem_barrier,
  output logic                      mem_restart
);
  import maap_pkg::*;

  // ****************************************
  // policy lookup
  // ****************************************
  logic [MAAP_CTRL_W-1:0] ctrl;
  maap_pol_if pol ();

  maap_classify u_classify (
    .pol (pol.cls)
  );

  // attributes go in as they come from the region lookup
  assign pol.mem_type = attr_type;                                   // [RL24]
  assign pol.cache = attr_cache;                                     // [RL24]
  assign pol.shareable = attr_shareable;                             // [RL24] [RL6]
  assign pol.read_only = attr_read_only;                             // [RL6]
  assign pol.write = req_write;
  assign pol.spec = req_spec;
  assign pol.size = req_size;
  assign pol.addr_lo = req_addr[1:0];
  assign pol.ctrl = ctrl;

  // hints only mean something while a request is offered
  assign hint_prefetch = req_valid && !req_barrier && pol.may_prefetch;  // [RL2]
  assign hint_repeat = req_valid && !req_barrier && pol.may_repeat;      // [RL2] [RL14]

  // ****************************************
  // write merge buffer state
  // ****************************************
  logic              mb_valid;
  logic [ADDR_W-1:0] mb_addr;
  logic [31:0]       mb_data;
  logic [3:0]        mb_strb;
  logic [1:0]        mb_size;
  logic              mb_cacheable;
  logic              mb_allocate;
  logic              mb_shareable;
  logic              mb_restart;

  logic       out_free;
  logic       same_word;
  logic [3:0] req_strb;
  logic       take;
  logic       fault;
  logic       flush;
  logic       load_mb;
  logic       merge_mb;
  logic       to_out;

  assign out_free = !mem_valid || mem_ready;

  // byte lanes of the request; lanes past the word are cut, unaligned data is pre-placed
  always_comb begin
    case (req_size)
      MAAP_SZ_BYTE: req_strb = MAAP_LANE_B << req_addr[1:0];
      MAAP_SZ_HALF: req_strb = MAAP_LANE_H << req_addr[1:0];
      default:      req_strb = MAAP_LANE_W << req_addr[1:0];
    endcase
  end

  // merge only into the same word with matching cacheability and shareability
  assign same_word = (mb_addr[ADDR_W-1:2] == req_addr[ADDR_W-1:2]) &&
                     (mb_cacheable == pol.cacheable) && (mb_shareable == attr_shareable);

  // ****************************************
  // request steering
  // ****************************************
  // the buffer only ever holds normal writes, so device traffic is never merged
  always_comb begin
    take = 1'b0;
    fault = 1'b0;
    flush = 1'b0;
    load_mb = 1'b0;
    merge_mb = 1'b0;
    to_out = 1'b0;
    if (req_valid && !req_barrier && pol.deny) begin
      take = 1'b1;                                                   // [RL15] [RL21]
      fault = 1'b1;
    end else if (req_valid && !req_barrier && pol.may_merge) begin
      if (!mb_valid) begin
        take = 1'b1;                                                 // [RL5]
        load_mb = 1'b1;
      end else if (same_word) begin
        take = 1'b1;                                                 // [RL5] [RL3]
        merge_mb = 1'b1;
      end else if (out_free) begin
        take = 1'b1;
        flush = 1'b1;
        load_mb = 1'b1;
      end
    end else if (mb_valid) begin
      // anything else, a barrier included, waits until merged data is out
      flush = out_free;                                              // [RL7] [RL17] [RL18]
    end else if (req_valid && out_free) begin
      take = 1'b1;                                                   // [RL13]
      to_out = 1'b1;
    end
  end

  assign req_ready = take;

  // ****************************************
  // merge buffer
  // ****************************************
  // a repeat of a merged write would replay every merged byte, since mb_strb gathers all lanes
  always_ff @(posedge clock) begin
    if (reset) begin
      mb_valid <= 1'b0;
      mb_addr <= '0;
      mb_data <= 32'h0;
      mb_strb <= 4'h0;
      mb_size <= MAAP_SZ_BYTE;
      mb_cacheable <= 1'b0;
      mb_allocate <= 1'b0;
      mb_shareable <= 1'b0;
      mb_restart <= 1'b0;
    end else if (load_mb) begin
      mb_valid <= 1'b1;
      mb_addr <= req_addr;
      mb_data <= req_wdata;
      mb_strb <= req_strb;
      mb_size <= req_size;
      mb_cacheable <= pol.cacheable;
      mb_allocate <= pol.allocate;
      mb_shareable <= attr_shareable;
      mb_restart <= req_restart;
    end else if (merge_mb) begin
      for (int i = 0; i < 4; i++) begin
        if (req_strb[i]) begin
          mb_data[8*i +: 8] <= req_wdata[8*i +: 8];                  // [RL5]
        end
      end
      mb_strb <= mb_strb | req_strb;
      mb_addr <= {req_addr[ADDR_W-1:2], 2'h0};
      mb_size <= MAAP_SZ_WORD;
      mb_restart <= mb_restart | req_restart;
    end else if (flush) begin
      mb_valid <= 1'b0;
    end
  end

  // ****************************************
  // memory side stage
  // ****************************************
  // a beat is held steady until taken, so nothing is dropped or reissued
  always_ff @(posedge clock) begin
    if (reset) begin
      mem_valid <= 1'b0;
      mem_addr <= '0;
      mem_write <= 1'b0;
      mem_size <= MAAP_SZ_BYTE;
      mem_wdata <= 32'h0;
      mem_strb <= 4'h0;
      mem_cacheable <= 1'b0;
      mem_allocate <= 1'b0;
      mem_shareable <= 1'b0;
      mem_excl <= 1'b0;
      mem_excl_global <= 1'b0;
      mem_device <= 1'b0;
      mem_local <= 1'b0;
      mem_barrier <= 1'b0;
      mem_restart <= 1'b0;
    end else if (flush) begin
      mem_valid <= 1'b1;
      mem_addr <= mb_addr;
      mem_write <= 1'b1;
      mem_size <= mb_size;
      mem_wdata <= mb_data;
      mem_strb <= mb_strb;
      mem_cacheable <= mb_cacheable;
      mem_allocate <= mb_allocate;
      mem_shareable <= mb_shareable;
      mem_excl <= 1'b0;
      mem_excl_global <= mb_shareable;
      mem_device <= 1'b0;
      mem_local <= 1'b0;
      mem_barrier <= 1'b0;
      mem_restart <= mb_restart;
    end else if (to_out) begin
      mem_valid <= 1'b1;
      mem_addr <= req_addr;
      mem_write <= req_write && !req_barrier;
      mem_size <= req_size;                                          // [RL13]
      mem_wdata <= req_wdata;
      mem_strb <= req_write ? req_strb : 4'h0;
      mem_cacheable <= pol.cacheable && !req_barrier;                // [RL16]
      mem_allocate <= pol.allocate && !req_barrier;                  // [RL16]
      mem_shareable <= pol.share_eff;
      mem_excl <= req_excl && !req_barrier;
      mem_excl_global <= pol.excl_global;                            // [RL8] [RL10]
      mem_device <= pol.is_device && !req_barrier;
      mem_local <= pol.is_device && !pol.share_eff && !req_barrier;  // [RL23]
      mem_barrier <= req_barrier;                                    // [RL7]
      mem_restart <= req_restart;                                    // [RL19]
    end else if (mem_ready) begin
      mem_valid <= 1'b0;
    end
  end

  // ****************************************
  // pipeline answer
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      resp_fault <= 1'b0;
      resp_code <= MAAP_OK;
    end else begin
      resp_fault <= fault;
      resp_code <= fault ? pol.deny_code : MAAP_OK;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [MAAP_CNT_W-1:0] cnt_issued;
  logic [MAAP_CNT_W-1:0] cnt_denied;
  maap_deny_t            last_code;
  logic                  seen_restart_dev;

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl <= MAAP_CTRL_RESET;
    end else if (reg_write && reg_addr == MAAP_REG_CTRL) begin
      ctrl <= reg_wdata[MAAP_CTRL_W-1:0];
    end
  end

  // counters wrap; software samples differences
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_issued <= '0;
    end else if (mem_valid && mem_ready) begin
      cnt_issued <= cnt_issued + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_denied <= '0;
      last_code <= MAAP_OK;
    end else if (fault) begin
      cnt_denied <= cnt_denied + 1'b1;
      last_code <= pol.deny_code;
    end
  end

  // sticky: a restarted device access shows software it may have repeated side effects
  always_ff @(posedge clock) begin
    if (reset) begin
      seen_restart_dev <= 1'b0;
    end else if (take && to_out && req_restart && pol.is_device) begin
      seen_restart_dev <= 1'b1;                                      // [RL19]
    end else if (reg_write && reg_addr == MAAP_REG_STATUS && reg_wdata[3]) begin
      seen_restart_dev <= 1'b0;
    end
  end

  // read data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      if (reg_addr == MAAP_REG_CTRL) begin
        reg_rdata <= {28'h0, ctrl};
      end else if (reg_addr == MAAP_REG_ISSUED) begin
        reg_rdata <= {16'h0, cnt_issued};
      end else if (reg_addr == MAAP_REG_DENIED) begin
        reg_rdata <= {16'h0, cnt_denied};
      end else if (reg_addr == MAAP_REG_STATUS) begin
        reg_rdata <= {27'h0, mb_valid, seen_restart_dev, last_code};
      end else begin
        reg_rdata <= 32'h0;
      end
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking chk_clk @(posedge clock);
  endclocking
  default disable iff (reset);

  chk_dev_no_spec: assert property ( // [RL15]
    req_valid && !req_barrier && attr_type == MAAP_DEVICE && req_spec
    |-> req_ready ##1 resp_fault && resp_code == MAAP_SPEC)
    else $error("speculative device access not refused");

  chk_dev_uncached: assert property ( // [RL16]
    mem_valid && mem_device |-> !mem_cacheable && !mem_allocate)
    else $error("device access marked cacheable");

  chk_dev_size: assert property ( // [RL13]
    to_out && pol.is_device |=> mem_valid && mem_size == $past(req_size)
    && mem_addr == $past(req_addr))
    else $error("device access size or address altered");

  chk_no_dev_merge: assert property ( // [RL17]
    load_mb || merge_mb |-> pol.is_normal && req_write)
    else $error("device write entered merge buffer");

  chk_beat_held: assert property ( // [RL14]
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr)
    && $stable(mem_write) && $stable(mem_size) && $stable(mem_device))
    else $error("pending beat dropped or changed");

  chk_excl_scope: assert property ( // [RL10]
    mem_valid && !mem_barrier |-> mem_excl_global == mem_shareable)
    else $error("exclusive scope differs from shareability");

  chk_share_nocache: assert property ( // [RL9]
    to_out && attr_type == MAAP_NORMAL && attr_shareable && !ctrl[MAAP_CB_SHCACHE]
    |=> !mem_cacheable)
    else $error("shared normal cached without coherency");

  chk_barrier_waits: assert property ( // [RL7]
    req_valid && req_barrier && mb_valid |-> !req_ready ##1 !mem_barrier)
    else $error("barrier passed merged writes");

  chk_ro_write: assert property ( // [RL6]
    req_valid && !req_barrier && attr_type == MAAP_NORMAL && attr_read_only && req_write
    |-> req_ready ##1 resp_fault && !$past(load_mb))
    else $error("write to read-only region not refused");

  chk_prefetch_hint: assert property ( // [RL2]
    hint_prefetch |-> attr_type == MAAP_NORMAL && !req_write)
    else $error("prefetch hinted outside normal reads");

endmodule

// ### tb/maap_mem_model.sv
`timescale 1ns/10ps
// ****************************************
// memory side partner
// ****************************************
module maap_mem_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // stall control
  input  wire logic        slow,
  // memory port
  input  wire logic        mem_valid,
  output logic             mem_ready,
  input  wire logic        mem_device,
  input  wire logic        mem_cacheable,
  input  wire logic        mem_allocate,
  input  wire logic [1:0]  mem_size,
  input  wire logic [3:0]  mem_strb,
  // observation
  output logic      [8:0]  last_beat,
  output logic      [15:0] beat_cnt
);
  // ready toggles when slow so the design must hold a beat across stalls
  always_ff @(posedge clock) begin
    mem_ready <= reset ? 1'b0 : (slow ? ~mem_ready : 1'b1);
  end
  // capture every accepted beat; the count shows merges and repeats
  always_ff @(posedge clock) begin
    if (reset) begin
      beat_cnt  <= 16'h0;
      last_beat <= 9'h0;
    end else if (mem_valid && mem_ready) begin
      beat_cnt  <= beat_cnt + 16'h1;
      last_beat <= {mem_device, mem_cacheable, mem_allocate, mem_size, mem_strb};
    end
  end
endmodule

// ### tb/maap_policy_bench.sv
`timescale 1ns/10ps
module maap_policy_bench;
  import maap_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic clock, reset, reg_write, reg_read, req_valid, req_ready, req_write, req_spec;
  logic req_excl, req_restart, req_barrier, attr_shareable, attr_read_only, slow;
  logic resp_fault, hint_prefetch, hint_repeat, mem_valid, mem_ready, mem_write;
  logic mem_cacheable, mem_allocate, mem_device;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, req_addr, req_wdata;
  logic [1:0]  req_size, mem_size;
  logic [3:0]  mem_strb;
  logic [8:0]  last_beat;
  logic [15:0] beat_cnt;
  maap_type_t  attr_type;
  maap_cache_t attr_cache;
  maap_deny_t  resp_code;
  int error_cnt = 0;
  int checks_done = 0;

  maap_policy maap_policy_inst (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr), .req_write(req_write),
    .req_size(req_size), .req_wdata(req_wdata), .req_spec(req_spec), .req_excl(req_excl),
    .req_restart(req_restart), .req_barrier(req_barrier), .attr_type(attr_type),
    .attr_cache(attr_cache), .attr_shareable(attr_shareable), .attr_read_only(attr_read_only),
    .resp_fault(resp_fault), .resp_code(resp_code), .hint_prefetch(hint_prefetch),
    .hint_repeat(hint_repeat), .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(),
    .mem_write(mem_write), .mem_size(mem_size), .mem_wdata(), .mem_strb(mem_strb),
    .mem_cacheable(mem_cacheable), .mem_allocate(mem_allocate), .mem_shareable(),
    .mem_excl(), .mem_excl_global(), .mem_device(mem_device), .mem_local(), .mem_barrier(),
    .mem_restart());
  maap_mem_model maap_mem_model_inst (.clock(clock), .reset(reset), .slow(slow),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_device(mem_device),
    .mem_cacheable(mem_cacheable), .mem_allocate(mem_allocate), .mem_size(mem_size),
    .mem_strb(mem_strb), .last_beat(last_beat), .beat_cnt(beat_cnt));

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk("rdata", exp, reg_rdata);
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // request stays up after a non-faulting take so back-to-back calls need no gap
  task automatic req(input logic w, input logic [1:0] sz, input logic [31:0] a,
                     input logic sp, input maap_type_t t, input maap_cache_t c,
                     input logic sh, input logic ro, input logic [1:0] hint,
                     input logic [2:0] code);
    int i;
    req_valid      <= 1'b1;
    req_write      <= w;
    req_size       <= sz;
    req_addr       <= a;
    req_spec       <= sp;
    attr_type      <= t;
    attr_cache     <= c;
    attr_shareable <= sh;
    attr_read_only <= ro;
    #1;
    chk("hints", 32'(hint), 32'({hint_prefetch, hint_repeat}));
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    if (code != 3'h0) begin
      req_valid <= 1'b0;
      #1;
      chk("fault", 32'h1, 32'(resp_fault));
      chk("code", 32'(code), 32'(resp_code));
      @(posedge clock);
    end
  endtask
  task automatic idle(input int n);
    req_valid <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  // bounded wait for the partner to have seen n beats
  task automatic beats(input logic [15:0] n);
    int i;
    for (i = 0; i < 40 && beat_cnt !== n; i++) begin
      @(posedge clock);
      #1;
    end
    chk("beats", 32'(n), 32'(beat_cnt));
    @(posedge clock);
  endtask

  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // the tests need well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    {reset, reg_write, reg_read, req_valid, req_write, req_spec, slow} = 7'h41;
    {req_excl, req_restart, req_barrier, attr_shareable, attr_read_only} = 5'h0;
    {reg_addr, reg_wdata, req_addr, req_size} = '0;
    req_wdata = 32'h0000_a55a;
    attr_type = MAAP_NORMAL;
    attr_cache = MAAP_NC;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(MAAP_REG_CTRL, 32'h7);
    rd(8'h10, 32'h0);
    slow <= 1'b1;
    req(0, MAAP_SZ_WORD, 32'h4000_0000, 0, MAAP_DEVICE, MAAP_WBWA, 0, 0, 2'b00, 0);
    idle(1);
    beats(16'h1);
    chk("dev_rd", 32'h12, 32'(last_beat[8:4]));
    slow <= 1'b0;
    req(1, MAAP_SZ_BYTE, 32'h4000_0010, 0, MAAP_DEVICE, MAAP_NC, 1, 0, 2'b00, 0);
    req(1, MAAP_SZ_BYTE, 32'h4000_0010, 0, MAAP_DEVICE, MAAP_NC, 1, 0, 2'b00, 0);
    idle(4);
    beats(16'h3);
    chk("dev_wr", 32'h101, 32'(last_beat));
    req(1, MAAP_SZ_BYTE, 32'h200, 0, MAAP_NORMAL, MAAP_WBWA, 0, 0, 2'b01, 0);
    req(1, MAAP_SZ_BYTE, 32'h201, 0, MAAP_NORMAL, MAAP_WBWA, 0, 0, 2'b01, 0);
    idle(8);
    beats(16'h4);
    chk("merge", 32'h0e3, 32'(last_beat));
    req(0, MAAP_SZ_HALF, 32'h301, 0, MAAP_NORMAL, MAAP_WT, 1, 0, 2'b11, 0);
    idle(3);
    beats(16'h5);
    chk("sh_rd", 32'h0d, 32'(last_beat[8:4]));
    wr(MAAP_REG_CTRL, 32'he);
    req(0, MAAP_SZ_BYTE, 32'h302, 0, MAAP_NORMAL, MAAP_WT, 1, 0, 2'b11, 0);
    idle(3);
    beats(16'h6);
    chk("sh_nc", 32'h00, 32'(last_beat[8:4]));
    req(0, MAAP_SZ_WORD, 32'h4000_0020, 1, MAAP_DEVICE, MAAP_NC, 0, 0, 2'b00, 2);
    req(0, MAAP_SZ_WORD, 32'h0000_0400, 0, MAAP_RSVD, MAAP_NC, 0, 0, 2'b00, 1);
    req(1, MAAP_SZ_WORD, 32'h0000_0500, 0, MAAP_NORMAL, MAAP_NC, 0, 1, 2'b01, 4);
    req(0, MAAP_SZ_WORD, 32'h4000_0001, 0, MAAP_DEVICE, MAAP_NC, 0, 0, 2'b00, 3);
    idle(4);
    beats(16'h6);
    rd(MAAP_REG_ISSUED, 32'h6);
    rd(MAAP_REG_DENIED, 32'h4);
    rd(MAAP_REG_STATUS, 32'h3);
    give_verdict();
  end
endmodule
